/* File: src/pbpf_defs.svh */
// constants for the port b pin function selector
`ifndef PBPF_DEFS_SVH
`define PBPF_DEFS_SVH
// register byte offsets on the bus
`define PBPF_OFF_UPPER 8'h00
`define PBPF_OFF_LOWER 8'h04
`define PBPF_OFF_DIR 8'h08
`define PBPF_OFF_DATA 8'h0C
// writable bit masks; reserved bits are held at zero
`define PBPF_MASK_UPPER 16'h7777
`define PBPF_MASK_LOWER 16'h7700
`define PBPF_MASK_PINS 16'h00FC
// reset values
`define PBPF_RST_REG 16'h0000
`define PBPF_RST_BIT 1'b0
`define PBPF_RST_OE_N 1'b1
// field positions (lsb of each 3-bit field)
`define PBPF_LSB_P7 12
`define PBPF_LSB_P6 8
`define PBPF_LSB_P5 4
`define PBPF_LSB_P4 0
`define PBPF_LSB_P3 12
`define PBPF_LSB_P2 8
// mode codes
`define PBPF_MD_PORT 3'h0
`define PBPF_MD_IRQ 3'h1
`define PBPF_MD_CANRX 3'h2
`define PBPF_MD_CANTX 3'h3
`define PBPF_MD_TCAP 3'h3
`define PBPF_MD_ADDR 3'h5
`define PBPF_MD_POE_HI 3'h7
`define PBPF_MD_POE_LO 3'h2
`define PBPF_MD_I2C 3'h4
// levels shown to a peripheral whose pin is not selected
`define PBPF_IDLE_IRQ 1'b1
`define PBPF_IDLE_POE 1'b1
`define PBPF_IDLE_TCAP 1'b0
`define PBPF_IDLE_CAN 1'b1
`define PBPF_IDLE_I2C 1'b1
`endif

/* File: src/pbpf_pkg.sv */
// types shared by the port b pin function selector
package pbpf_pkg;
  typedef logic [2:0] pbpf_mode_t;
  typedef enum logic [1:0] {
    PBPF_RESP_OKAY = 2'b00,
    PBPF_RESP_SLVERR = 2'b10
  } pbpf_resp_t;
endpackage : pbpf_pkg

/* File: src/pbpf_pin_cell.sv */
// one package pin: input synchroniser and registered drive
`timescale 1ns/100ps
`include "pbpf_defs.svh"
module pbpf_pin_cell (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // package pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n,
  // core side
  input wire logic drive_en,
  input wire logic drive_val,
  output logic level
);
  import pbpf_pkg::*;
  logic s1_r, s2_r, s3_r, level_r, out_r, oe_n_r;
  logic level_nxt;

  ////////////////////////////////////////////////////////////////////////
  // level moves only once the last two stages agree, so a single
  // metastable sample cannot reach the peripherals
  assign level_nxt = (s2_r == s3_r) ? s3_r : level_r;

  // three-stage synchroniser; s1_r feeds s2_r only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= `PBPF_RST_BIT;
      s2_r <= `PBPF_RST_BIT;
      s3_r <= `PBPF_RST_BIT;
      level_r <= `PBPF_RST_BIT;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  // registered drive keeps mux glitches off the pad
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= `PBPF_RST_BIT;
      oe_n_r <= `PBPF_RST_OE_N;
    end else begin
      out_r <= drive_val;
      oe_n_r <= ~drive_en;
    end
  end

  assign pin_o = out_r;
  assign pin_oe_n = oe_n_r;
  assign level = level_r;
endmodule : pbpf_pin_cell

/* File: src/pbpf_top.sv */
// port b pin function selector with axi4-lite register slave
// Notes on behaviour
// - reserved bits read zero, software writes zero
// - pin7 bits 14:12, 000 port, 010 can receive
// - pin6 bits 10:8, 000 port, 011 can transmit
// - pin5 bits 6:4: ext_interrupt_line3, capture, addr19, oe5
// - pin4 bits 2:0: ext_interrupt_line2, capture, addr18, oe4
// - lower register low byte reserved, reads zero
// - 3-bit fields in 4-bit slots, top reserved
// - port mode: direction bit one means output
// - direction ignored under any peripheral selection
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pbpf_defs.svh"
module pbpf_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output pbpf_pkg::pbpf_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output pbpf_pkg::pbpf_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // package pins 7 to 2
  input wire logic [7:2] pin_i,
  output logic [7:2] pin_o,
  output logic [7:2] pin_oe_n,
  // can unit
  output logic can_receive_line,
  input wire logic can_transmit_line,
  // interrupt controller unit
  output logic ext_interrupt_line3,
  output logic ext_interrupt_line2,
  output logic ext_interrupt_line1,
  output logic ext_interrupt_line0,
  // port output enable unit
  output logic output_enable_input5,
  output logic output_enable_input4,
  output logic output_enable_input1,
  output logic output_enable_input0,
  // timers
  output logic timer_capture_u,
  output logic secondary_timer_capture_u,
  output logic timer_capture_v,
  output logic secondary_timer_capture_v,
  // bus state controller
  input wire logic addr_bit19,
  input wire logic addr_bit18,
  // i2c unit
  input wire logic i2c_sda_o,
  input wire logic i2c_sda_oe_n,
  output logic i2c_sda_i,
  input wire logic i2c_scl_o,
  input wire logic i2c_scl_oe_n,
  output logic i2c_scl_i
);
  import pbpf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // one-hot hit vector: {data, dir, lower, upper}
  function automatic logic [3:0] pbpf_decode(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return {w == `PBPF_OFF_DATA, w == `PBPF_OFF_DIR,
            w == `PBPF_OFF_LOWER, w == `PBPF_OFF_UPPER};
  endfunction : pbpf_decode

  // byte-lane merge; reserved bits fall away through the mask
  function automatic logic [15:0] pbpf_merge(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] st, input logic [15:0] m);
    logic [15:0] v;
    v[7:0] = st[0] ? wd[7:0] : old[7:0];
    v[15:8] = st[1] ? wd[15:8] : old[15:8];
    return v & m;
  endfunction : pbpf_merge

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] upper_r, lower_r, dir_r, data_r;
  logic [15:0] upper_nxt, lower_nxt, dir_nxt, data_nxt;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  pbpf_resp_t bresp_r, rresp_r;
  logic [7:2] lvl, drv_en, drv_val, port_sel;
  pbpf_mode_t m7, m6, m5, m4, m3, m2;
  logic aw_take, w_take, ar_take, do_write;
  logic [3:0] whit, rhit;
  logic [15:0] rmux;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes: one write and one read outstanding
  assign awready = ~aw_held_r & ~bvalid_r;
  assign wready = ~w_held_r & ~bvalid_r;
  assign arready = ~rvalid_r;
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign do_write = aw_held_r & w_held_r;
  assign whit = pbpf_decode(awaddr_r);
  assign rhit = pbpf_decode(araddr);

  // address and data are latched apart so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= PBPF_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (|whit) ? PBPF_RESP_OKAY : PBPF_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register updates
  // reserved bits masked
  assign upper_nxt = (do_write & whit[0]) ?
      pbpf_merge(upper_r, wdata_r, wstrb_r, `PBPF_MASK_UPPER) : upper_r;
  assign lower_nxt = (do_write & whit[1]) ?
      pbpf_merge(lower_r, wdata_r, wstrb_r, `PBPF_MASK_LOWER) : lower_r;
  assign dir_nxt = (do_write & whit[2]) ?
      pbpf_merge(dir_r, wdata_r, wstrb_r, `PBPF_MASK_PINS) : dir_r;
  assign data_nxt = (do_write & whit[3]) ?
      pbpf_merge(data_r, wdata_r, wstrb_r, `PBPF_MASK_PINS) : data_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_r <= `PBPF_RST_REG;
      lower_r <= `PBPF_RST_REG;
      dir_r <= `PBPF_RST_REG;
      data_r <= `PBPF_RST_REG;
    end else begin
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      dir_r <= dir_nxt;
      data_r <= data_nxt;
    end
  end

  // read mux; the data register reads the synchronised pin levels
  assign rmux = rhit[0] ? upper_r :
                rhit[1] ? lower_r :
                rhit[2] ? dir_r :
                rhit[3] ? ({8'h00, lvl, 2'b00} & `PBPF_MASK_PINS) :
                16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= PBPF_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rmux};
      rresp_r <= (|rhit) ? PBPF_RESP_OKAY : PBPF_RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////
  // mode fields
  assign m7 = upper_r[`PBPF_LSB_P7 +: 3];
  assign m6 = upper_r[`PBPF_LSB_P6 +: 3];
  assign m5 = upper_r[`PBPF_LSB_P5 +: 3];
  assign m4 = upper_r[`PBPF_LSB_P4 +: 3];
  assign m3 = lower_r[`PBPF_LSB_P3 +: 3];
  assign m2 = lower_r[`PBPF_LSB_P2 +: 3];
  assign port_sel = {m7 == `PBPF_MD_PORT, m6 == `PBPF_MD_PORT,
                     m5 == `PBPF_MD_PORT, m4 == `PBPF_MD_PORT,
                     m3 == `PBPF_MD_PORT, m2 == `PBPF_MD_PORT};

  // pin drive; a prohibited code leaves the pin undriven
  // direction in port mode
  assign drv_en[7] = port_sel[7] & dir_r[7];
  assign drv_val[7] = data_r[7];
  assign drv_en[6] = port_sel[6] ? dir_r[6] : (m6 == `PBPF_MD_CANTX);
  assign drv_val[6] = port_sel[6] ? data_r[6] : can_transmit_line;
  assign drv_en[5] = port_sel[5] ? dir_r[5] : (m5 == `PBPF_MD_ADDR);
  assign drv_val[5] = port_sel[5] ? data_r[5] : addr_bit19;
  assign drv_en[4] = port_sel[4] ? dir_r[4] : (m4 == `PBPF_MD_ADDR);
  assign drv_val[4] = port_sel[4] ? data_r[4] : addr_bit18;
  assign drv_en[3] = port_sel[3] ? dir_r[3] :
                     ((m3 == `PBPF_MD_I2C) & ~i2c_sda_oe_n);
  assign drv_val[3] = port_sel[3] ? data_r[3] : i2c_sda_o;
  assign drv_en[2] = port_sel[2] ? dir_r[2] :
                     ((m2 == `PBPF_MD_I2C) & ~i2c_scl_oe_n);
  assign drv_val[2] = port_sel[2] ? data_r[2] : i2c_scl_o;

  // pin cells
  for (genvar p = 2; p <= 7; p++) begin : g_pin
    pbpf_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_i(pin_i[p]),
      .pin_o(pin_o[p]),
      .pin_oe_n(pin_oe_n[p]),
      .drive_en(drv_en[p]),
      .drive_val(drv_val[p]),
      .level(lvl[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // inputs toward peripherals, idle unless their pin is selected
  // unselected inputs idle
  assign can_receive_line = (m7 == `PBPF_MD_CANRX) ? lvl[7] : `PBPF_IDLE_CAN;
  assign ext_interrupt_line3 = (m5 == `PBPF_MD_IRQ) ? lvl[5] : `PBPF_IDLE_IRQ;
  assign timer_capture_u = (m5 == `PBPF_MD_TCAP) ? lvl[5] : `PBPF_IDLE_TCAP;
  assign output_enable_input5 =
      (m5 == `PBPF_MD_POE_HI) ? lvl[5] : `PBPF_IDLE_POE;
  assign ext_interrupt_line2 = (m4 == `PBPF_MD_IRQ) ? lvl[4] : `PBPF_IDLE_IRQ;
  assign secondary_timer_capture_u =
      (m4 == `PBPF_MD_TCAP) ? lvl[4] : `PBPF_IDLE_TCAP;
  assign output_enable_input4 =
      (m4 == `PBPF_MD_POE_HI) ? lvl[4] : `PBPF_IDLE_POE;
  assign ext_interrupt_line1 = (m3 == `PBPF_MD_IRQ) ? lvl[3] : `PBPF_IDLE_IRQ;
  assign output_enable_input1 =
      (m3 == `PBPF_MD_POE_LO) ? lvl[3] : `PBPF_IDLE_POE;
  assign timer_capture_v = (m3 == `PBPF_MD_TCAP) ? lvl[3] : `PBPF_IDLE_TCAP;
  assign i2c_sda_i = (m3 == `PBPF_MD_I2C) ? lvl[3] : `PBPF_IDLE_I2C;
  assign ext_interrupt_line0 = (m2 == `PBPF_MD_IRQ) ? lvl[2] : `PBPF_IDLE_IRQ;
  assign output_enable_input0 =
      (m2 == `PBPF_MD_POE_LO) ? lvl[2] : `PBPF_IDLE_POE;
  assign secondary_timer_capture_v =
      (m2 == `PBPF_MD_TCAP) ? lvl[2] : `PBPF_IDLE_TCAP;
  assign i2c_scl_i = (m2 == `PBPF_MD_I2C) ? lvl[2] : `PBPF_IDLE_I2C;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rsvd_read_zero: assert property (
    ar_take && rhit[0] |=> (rdata[31:0] & ~{16'h0000, `PBPF_MASK_UPPER})
                           == 32'h0000_0000)
    else $error("reserved upper bits read nonzero");
  chk_canrx_route: assert property (
    can_receive_line == ((m7 == `PBPF_MD_CANRX) ? lvl[7] : `PBPF_IDLE_CAN))
    else $error("can receive routing wrong");
  chk_cantx_drive: assert property (
    m6 == `PBPF_MD_CANTX ##1 m6 == `PBPF_MD_CANTX |->
      !pin_oe_n[6] && pin_o[6] == $past(can_transmit_line))
    else $error("can transmit not driven on pin6");
  chk_addr19_drive: assert property (
    m5 == `PBPF_MD_ADDR |=> !pin_oe_n[5] && pin_o[5] == $past(addr_bit19))
    else $error("addr19 not driven on pin5");
  chk_ext_interrupt_line2_route: assert property (
    m4 == `PBPF_MD_IRQ |-> ext_interrupt_line2 == lvl[4]
                           && secondary_timer_capture_u == `PBPF_IDLE_TCAP)
    else $error("pin4 interrupt routing wrong");
  chk_sda_open_drain: assert property (
    m3 == `PBPF_MD_I2C |-> i2c_sda_i == lvl[3]
                           ##1 pin_oe_n[3] == $past(i2c_sda_oe_n))
    else $error("sda enable not passed");
  chk_output_enable_input0_route: assert property (
    m2 == `PBPF_MD_POE_LO |-> output_enable_input0 == lvl[2]
                              && ext_interrupt_line0 == `PBPF_IDLE_IRQ)
    else $error("pin2 output enable routing wrong");
  chk_low_byte_zero: assert property (
    do_write && whit[1] |=> lower_r[7:0] == 8'h00)
    else $error("lower low byte not zero");
  chk_reset_port: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> upper_r == `PBPF_RST_REG && lower_r == `PBPF_RST_REG)
    else $error("modes not cleared by reset");
  chk_field_write: assert property (
    do_write && whit[0] && wstrb_r[1:0] == 2'b11 |=>
      upper_r == ($past(wdata_r[15:0]) & `PBPF_MASK_UPPER))
    else $error("upper write not stored");
  chk_dir_port: assert property (
    port_sel[5] ##1 port_sel[5] |-> pin_oe_n[5] == !$past(dir_r[5]))
    else $error("direction not applied");
  chk_dir_ignored: assert property (
    !port_sel[7] |=> pin_oe_n[7])
    else $error("pin7 driven outside port mode");
  chk_route_timing: assert property (
    do_write && whit[1] && wstrb_r[1] |=>
      m2 == $past(wdata_r[`PBPF_LSB_P2 +: 3]))
    else $error("routing did not follow write");

  cov_upper_write: cover property (do_write && whit[0]);
  cov_read_back: cover property (ar_take ##1 rvalid && rready);
  cov_i2c_mode: cover property (m3 == `PBPF_MD_I2C && !pin_oe_n[3]);
  cov_addr_mode: cover property (m4 == `PBPF_MD_ADDR ##1 !pin_oe_n[4]);
endmodule : pbpf_top

/* File: dv/pbpf_pad_model.sv */
// far-side pad model: resolves each package pin from its drive enable
`timescale 1ns/100ps
module pbpf_pad_model (
  // design side
  input wire logic [7:2] pin_o,
  input wire logic [7:2] pin_oe_n,
  // outside world level seen while the pad is released
  input wire logic [7:2] ext,
  output logic [7:2] pin_i
);
  //////////////////////////////////////////////////////////////////////////
  // a released pad shows the outside level, never the last driven value
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ext);
endmodule : pbpf_pad_model

/* File: dv/tb.sv */
// self-checking bench for the port b pin function selector
`timescale 1ns/100ps
`include "pbpf_defs.svh"
module tb;
  import pbpf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  pbpf_resp_t bresp, rresp;
  logic [31:0] rdata;
  logic [7:2] pin_i, pin_o, pin_oe_n;
  logic [7:2] ext = 6'h00;
  logic can_receive_line, ext_interrupt_line3, ext_interrupt_line2;
  logic ext_interrupt_line1, ext_interrupt_line0, output_enable_input5;
  logic output_enable_input4, output_enable_input1, output_enable_input0;
  logic timer_capture_u, secondary_timer_capture_u, timer_capture_v;
  logic secondary_timer_capture_v, i2c_sda_i, i2c_scl_i;
  logic can_transmit_line = 1'b1, addr_bit19 = 1'b0, addr_bit18 = 1'b0;
  logic i2c_sda_o = 1'b1, i2c_sda_oe_n = 1'b1;
  logic i2c_scl_o = 1'b1, i2c_scl_oe_n = 1'b1;
  logic [14:0] per;
  int failures = 0;
  int samples_checked = 0;
  logic [33:0] expq[$];
  logic [2:0] m [2:7];
  logic [2:0] c54 [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  logic [2:0] c32 [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

  //////////////////////////////////////////////////////////////////////////
  // clock, design and pads
  always #2 aclk = ~aclk;
  pbpf_top DUT (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .pin_i, .pin_o, .pin_oe_n,
    .can_receive_line, .can_transmit_line, .ext_interrupt_line3,
    .ext_interrupt_line2, .ext_interrupt_line1, .ext_interrupt_line0,
    .output_enable_input5, .output_enable_input4, .output_enable_input1,
    .output_enable_input0, .timer_capture_u, .secondary_timer_capture_u,
    .timer_capture_v, .secondary_timer_capture_v, .addr_bit19, .addr_bit18,
    .i2c_sda_o, .i2c_sda_oe_n, .i2c_sda_i, .i2c_scl_o, .i2c_scl_oe_n,
    .i2c_scl_i
  );
  pbpf_pad_model u_pad (.pin_o, .pin_oe_n, .ext, .pin_i);
  assign per = {can_receive_line, ext_interrupt_line3, ext_interrupt_line2,
    ext_interrupt_line1, ext_interrupt_line0, output_enable_input5,
    output_enable_input4, output_enable_input1, output_enable_input0,
    timer_capture_u, secondary_timer_capture_u, timer_capture_v,
    secondary_timer_capture_v, i2c_sda_i, i2c_scl_i};

  //////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus tasks
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic sel(input logic hit, lv, idle);
    return hit ? lv : idle;
  endfunction : sel

  // entered just after a rising edge; each half released once taken
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d,
      input pbpf_resp_t er);
    expq.push_back({er, 32'h0000_0000});
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid !== 1'b0 || wvalid !== 1'b0 || bready !== 1'b1) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (!(awvalid && !awready) && !(wvalid && !wready)) break;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    // an edge passes so a following call never re-raises in this step
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
      input pbpf_resp_t er);
    expq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  // watcher: each answer is matched against the oldest note
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk({bresp, 32'h0000_0000}, expq.pop_front());
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk({rresp, rdata}, expq.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one routing step: listed codes only, sources randomised
  task automatic step(input int i);
    int unsigned k;
    logic [15:0] up, lo;
    logic [7:2] dir, dat, drv, val, pad;
    logic [14:0] ep;
    k = (i < 10) ? i : $urandom;
    // listed codes only, external-extension mode assumed
    m[7] = (k % 2) ? 3'h2 : 3'h0;
    m[6] = ((k + 1) % 2) ? 3'h3 : 3'h0;
    m[5] = c54[k % 5];
    m[4] = c54[(k + 2) % 5];
    m[3] = c32[(k + 1) % 5];
    m[2] = c32[(k + 3) % 5];
    ext <= 6'($urandom);
    can_transmit_line <= 1'($urandom);
    addr_bit19 <= 1'($urandom);
    addr_bit18 <= 1'($urandom);
    i2c_sda_o <= 1'($urandom);
    i2c_sda_oe_n <= 1'($urandom);
    i2c_scl_o <= 1'($urandom);
    i2c_scl_oe_n <= 1'($urandom);
    dir = 6'($urandom);
    dat = 6'($urandom);
    up = {1'b0, m[7], 1'b0, m[6], 1'b0, m[5], 1'b0, m[4]};
    lo = {1'b0, m[3], 1'b0, m[2], 8'h00};
    axi_write(`PBPF_OFF_DIR, {8'h00, dir, 2'b00}, PBPF_RESP_OKAY);
    axi_write(`PBPF_OFF_DATA, {8'h00, dat, 2'b00}, PBPF_RESP_OKAY);
    axi_write(`PBPF_OFF_UPPER, up, PBPF_RESP_OKAY);
    axi_write(`PBPF_OFF_LOWER, lo, PBPF_RESP_OKAY);
    repeat (8) @(posedge aclk);
    for (int p = 2; p < 8; p++) begin
      drv[p] = (m[p] == 3'h0) ? dir[p] : 1'b0;
      val[p] = dat[p];
    end
    val[6] = (m[6] == 3'h3) ? can_transmit_line : val[6];
    drv[6] = drv[6] | (m[6] == 3'h3);
    val[5] = (m[5] == 3'h5) ? addr_bit19 : val[5];
    drv[5] = drv[5] | (m[5] == 3'h5);
    val[4] = (m[4] == 3'h5) ? addr_bit18 : val[4];
    drv[4] = drv[4] | (m[4] == 3'h5);
    val[3] = (m[3] == 3'h4) ? i2c_sda_o : val[3];
    drv[3] = drv[3] | (m[3] == 3'h4 && !i2c_sda_oe_n);
    val[2] = (m[2] == 3'h4) ? i2c_scl_o : val[2];
    drv[2] = drv[2] | (m[2] == 3'h4 && !i2c_scl_oe_n);
    pad = (drv & val) | (~drv & ext);
    ep = {sel(m[7] == 3'h2, pad[7], `PBPF_IDLE_CAN),
      sel(m[5] == 3'h1, pad[5], `PBPF_IDLE_IRQ),
      sel(m[4] == 3'h1, pad[4], `PBPF_IDLE_IRQ),
      sel(m[3] == 3'h1, pad[3], `PBPF_IDLE_IRQ),
      sel(m[2] == 3'h1, pad[2], `PBPF_IDLE_IRQ),
      sel(m[5] == 3'h7, pad[5], `PBPF_IDLE_POE),
      sel(m[4] == 3'h7, pad[4], `PBPF_IDLE_POE),
      sel(m[3] == 3'h2, pad[3], `PBPF_IDLE_POE),
      sel(m[2] == 3'h2, pad[2], `PBPF_IDLE_POE),
      sel(m[5] == 3'h3, pad[5], `PBPF_IDLE_TCAP),
      sel(m[4] == 3'h3, pad[4], `PBPF_IDLE_TCAP),
      sel(m[3] == 3'h3, pad[3], `PBPF_IDLE_TCAP),
      sel(m[2] == 3'h3, pad[2], `PBPF_IDLE_TCAP),
      sel(m[3] == 3'h4, pad[3], `PBPF_IDLE_I2C),
      sel(m[2] == 3'h4, pad[2], `PBPF_IDLE_I2C)};
    // the cast keeps the inversion at pin width
    chk(pin_oe_n, 6'(~drv));
    chk(pin_o & drv, val & drv);
    chk(per, ep);
    axi_read(`PBPF_OFF_UPPER, {16'h0000, up}, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_LOWER, {16'h0000, lo}, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_DATA, {24'h00_0000, pad, 2'b00},
      PBPF_RESP_OKAY);
  endtask : step

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hf4ad));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(pin_oe_n, 6'h3f);
    chk(per, {`PBPF_IDLE_CAN, {4{`PBPF_IDLE_IRQ}}, {4{`PBPF_IDLE_POE}},
      {4{`PBPF_IDLE_TCAP}}, {2{`PBPF_IDLE_I2C}}});
    axi_read(`PBPF_OFF_UPPER, 32'h0000_0000, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_LOWER, 32'h0000_0000, PBPF_RESP_OKAY);
    // reserved slots written with ones on purpose
    axi_write(`PBPF_OFF_UPPER, 16'h8888, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_UPPER, 32'h0000_0000, PBPF_RESP_OKAY);
    axi_write(`PBPF_OFF_LOWER, 16'h84ff, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_LOWER, 32'h0000_0400, PBPF_RESP_OKAY);
    axi_write(8'h10, 16'h1234, PBPF_RESP_SLVERR);
    axi_read(8'h10, 32'h0000_0000, PBPF_RESP_SLVERR);
    for (int i = 0; i < 30; i++) step(i);
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(`PBPF_OFF_UPPER, 32'h0000_0000, PBPF_RESP_OKAY);
    axi_read(`PBPF_OFF_LOWER, 32'h0000_0000, PBPF_RESP_OKAY);
    chk(pin_oe_n, 6'h3f);
    report_and_stop();
  end

  // watchdog well beyond the expected run of roughly a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
endmodule : tb
